// [design/lpmc_pkg.sv]
// package: timing constants and states of the low power mode control
// assumes a 100 MHz system clock
package lpmc_pkg;
  localparam int unsigned CLK_PERIOD_NS   = 10;
  localparam int unsigned ENTRY_TIME_NS   = 800;
  localparam int unsigned EXIT_TIME_US    = 200;
  localparam int unsigned INIT_CYCLES     = 16;
  // entry needs strictly longer than 800 ns: one cycle beyond the count
  localparam int unsigned ENTRY_CYCLES    = ENTRY_TIME_NS / CLK_PERIOD_NS + 1;
  // exit needs strictly longer than 200 us
  localparam int unsigned EXIT_CYCLES     =
    (EXIT_TIME_US * 1000) / CLK_PERIOD_NS + 1;
  localparam int unsigned CNT_W           = 16;
  typedef enum logic [1:0] {
    LPMC_RUN,
    LPMC_SLEEP,
    LPMC_INIT
  } lpmc_state_t;
endpackage : lpmc_pkg

// [design/lpmc_sync.sv]
// two flip-flop synchroniser for the sleep request pin
// assumes the pin is asynchronous to clk_i
`timescale 1ns/100ps
module lpmc_sync (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  // async level in, synced level out
  input  wire logic async_i,
  output logic      sync_o
);
  logic meta_r;
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      meta_r <= 1'b0;
      sync_o <= 1'b0;
    end
    else
    begin
      meta_r <= async_i;
      sync_o <= meta_r;
    end
  end
endmodule : lpmc_sync

// [design/lpmc_ctrl.sv]
// low power mode control: sleep entry and exit sequencing
// assumes one 100 MHz clock and an external controller on the pin
//
// How it works
// - sleep is entered only after the pin stays high over 800 ns.
// - in sleep the core enable is dropped so the core draws no power.
// - in sleep the input buffer enable is dropped.
// - in sleep all output and bidirectional drivers are released.
// - entering sleep clears the core state through a register wipe.
// - after the low interval the device starts initialization itself.
`timescale 1ns/100ps
module lpmc_ctrl (
  // clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  sys_rst_i,
  // sleep request pin
  input  wire logic                  sleep_request_pin_i,
  // core and pad controls
  output logic                       core_en_o,
  output logic                       in_buf_en_o,
  output logic                       out_drv_en_o,
  output logic                       reg_wipe_o,
  output logic                       init_start_o,
  output logic                       init_busy_o,
  output lpmc_pkg::lpmc_state_t      state_o
);
  import lpmc_pkg::*;

  logic                 req_s;
  logic [CNT_W-1:0]     cnt_r;
  logic [CNT_W-1:0]     cnt_nxt;
  lpmc_state_t          state_r;
  lpmc_state_t          state_nxt;

  localparam logic [CNT_W-1:0] ENTRY_CNT = CNT_W'(ENTRY_CYCLES);
  localparam logic [CNT_W-1:0] EXIT_CNT  = CNT_W'(EXIT_CYCLES);
  localparam logic [CNT_W-1:0] INIT_CNT  = CNT_W'(INIT_CYCLES);

  lpmc_sync u_sync (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .async_i   (sleep_request_pin_i),
    .sync_o    (req_s)
  );

  wire run_st   = (state_r == LPMC_RUN);
  wire sleep_st = (state_r == LPMC_SLEEP);
  wire init_st  = (state_r == LPMC_INIT);
  // count high time in run, low time in sleep, init length in init
  wire counting = (run_st & req_s) | (sleep_st & ~req_s) | init_st;
  wire enter_go = run_st & req_s & (cnt_r == ENTRY_CNT - 16'h0001);
  wire exit_go  = sleep_st & ~req_s &
                  (cnt_r == EXIT_CNT - 16'h0001);
  wire init_end = init_st & (cnt_r == INIT_CNT - 16'h0001);

  assign cnt_nxt = (enter_go | exit_go | init_end | ~counting) ? 16'h0000
                 : cnt_r + 16'h0001;

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      LPMC_RUN:
        if (enter_go)
          state_nxt = LPMC_SLEEP;
      LPMC_SLEEP:
        if (exit_go)
          state_nxt = LPMC_INIT;
      LPMC_INIT:
        if (req_s)
          state_nxt = LPMC_RUN;
        else if (init_end)
          state_nxt = LPMC_RUN;
      default:
        state_nxt = LPMC_RUN;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      state_r <= LPMC_RUN;
      cnt_r   <= 16'h0000;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r   <= (state_nxt != state_r) ? 16'h0000 : cnt_nxt;
    end
  end

  wire nxt_awake = (state_nxt != LPMC_SLEEP);

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      core_en_o    <= 1'b1;
      in_buf_en_o  <= 1'b1;
      out_drv_en_o <= 1'b1;
      reg_wipe_o   <= 1'b0;
      init_start_o <= 1'b0;
      init_busy_o  <= 1'b0;
      state_o      <= LPMC_RUN;
    end
    else
    begin
      core_en_o    <= nxt_awake;
      in_buf_en_o  <= nxt_awake;
      out_drv_en_o <= nxt_awake;
      reg_wipe_o   <= ~nxt_awake;
      init_start_o <= exit_go;
      init_busy_o  <= (state_nxt == LPMC_INIT);
      state_o      <= state_nxt;
    end
  end

  // helper: length of the current low stretch in sleep
  int unsigned low_run_r;
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i | ~sleep_st | req_s)
      low_run_r <= 0;
    else
      low_run_r <= low_run_r + 1;
  end

  // helper: length of the current high stretch in run
  int unsigned high_run_r;
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i | ~run_st | ~req_s)
      high_run_r <= 0;
    else
      high_run_r <= high_run_r + 1;
  end

  // helper: cycles spent in the current init phase
  int unsigned init_run_r;
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i | ~init_st)
      init_run_r <= 0;
    else
      init_run_r <= init_run_r + 1;
  end

  a_entry_min: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    $rose(state_r == LPMC_SLEEP) |-> $past(req_s, 1))
    else $error("sleep entered without request high");

  a_entry_time: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    run_st && req_s && high_run_r == ENTRY_CYCLES - 1 |=> sleep_st)
    else $error("sleep not entered after 810 ns high");

  a_entry_early: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    run_st && !(req_s && high_run_r == ENTRY_CYCLES - 1) |=> !sleep_st)
    else $error("sleep entered before 810 ns high");

  a_short_pulse: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    run_st && !req_s ##1 req_s [*8] ##1 !req_s |-> run_st)
    else $error("short pulse caused sleep");

  a_core_off: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    sleep_st |-> !core_en_o)
    else $error("core enabled in sleep");

  a_pads_on: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    !sleep_st |-> core_en_o && in_buf_en_o && out_drv_en_o && !reg_wipe_o)
    else $error("core or pads off while awake");

  a_inbuf_off: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    sleep_st |-> !in_buf_en_o && !out_drv_en_o)
    else $error("buffers enabled in sleep");

  a_drv_off: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    out_drv_en_o |-> state_o != LPMC_SLEEP)
    else $error("drivers on in sleep");

  a_wipe_sleep: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    reg_wipe_o == (state_o == LPMC_SLEEP))
    else $error("wipe does not match sleep");

  a_exit_time: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    sleep_st && !req_s && low_run_r == EXIT_CYCLES - 1 |=>
      init_st && init_start_o)
    else $error("init not started after low interval");

  a_no_early: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    $rose(init_st) |-> $past(low_run_r, 1) == EXIT_CYCLES - 1)
    else $error("wakeup before low interval");

  a_start_once: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    init_start_o |-> init_st ##1 !init_start_o)
    else $error("init start not a single pulse in init");

  a_init_hold: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    init_st && !req_s && init_run_r < INIT_CYCLES - 1 |=>
      init_st && init_busy_o)
    else $error("init phase ended early");

  a_init_len: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    init_st && !req_s && init_run_r == INIT_CYCLES - 1 |=>
      run_st && !init_busy_o)
    else $error("init phase did not end on time");

  c_sleep: cover property (@(posedge clk_i) $rose(sleep_st));
  c_wake:  cover property (@(posedge clk_i) $rose(init_st));
  c_short: cover property (@(posedge clk_i) run_st && $fell(req_s));
  c_done:  cover property (@(posedge clk_i) init_end);
  c_abort: cover property (@(posedge clk_i) init_st && req_s);
endmodule : lpmc_ctrl

// [verif/lpmc_host.sv]
// partner model: system controller on the sleep request pin
// assumes the bench calls pulse; the pin changes at falling edges
`timescale 1ns/100ps
module lpmc_host (
  // clock
  input  wire logic clk_i,
  // sleep request pin
  output logic      sleep_request_pin_o
);
  // pin driven to a defined level from time zero
  initial sleep_request_pin_o = 1'b0;
  // high for n cycles, then held low until the next call
  task automatic pulse(input int unsigned n);
    @(negedge clk_i) sleep_request_pin_o = 1'b1;
    repeat (n) @(negedge clk_i);
    sleep_request_pin_o = 1'b0;
  endtask : pulse
endmodule : lpmc_host

// [verif/tb_top.sv]
// bench: short pulses, threshold entry, wake and init
// assumes lpmc_ctrl alone with lpmc_host driving its pin
`timescale 1ns/100ps
module tb_top;
  import lpmc_pkg::*;
  logic        clk_i, sys_rst_i, pin, init_start_o, init_busy_o;
  logic        core_en_o, in_buf_en_o, out_drv_en_o, reg_wipe_o;
  lpmc_state_t state_o, last_state;
  logic [5:0]  exp_q[$];
  int          errors, samples_checked, n, starts, busy_cyc;
  lpmc_host lpmc_host_i (.clk_i(clk_i), .sleep_request_pin_o(pin));
  lpmc_ctrl lpmc_ctrl_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .sleep_request_pin_i(pin), .core_en_o(core_en_o),
    .in_buf_en_o(in_buf_en_o), .out_drv_en_o(out_drv_en_o),
    .reg_wipe_o(reg_wipe_o), .init_start_o(init_start_o),
    .init_busy_o(init_busy_o), .state_o(state_o));
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("checked %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish
  // watches outputs; each state change takes the oldest note
  always @(posedge clk_i)
  begin
    #1;
    if (init_start_o === 1'b1) starts++;
    if (init_busy_o === 1'b1) busy_cyc++;
    if (state_o !== last_state && sys_rst_i === 1'b0)
    begin
      last_state = state_o;
      if (exp_q.size() == 0)
        check(state_o, 32'h3);
      else
        check({state_o, core_en_o, in_buf_en_o, out_drv_en_o, reg_wipe_o},
          exp_q.pop_front());
    end
  end
  initial
  begin
    #300000;
    errors++;
    tally_and_finish();
  end
  initial
  begin
    sys_rst_i = 1'b1;
    last_state = LPMC_RUN;
    errors = 0;
    samples_checked = 0;
    starts = 0;
    busy_cyc = 0;
    void'($urandom(32'h9cf1));
    repeat (3) @(negedge clk_i);
    sys_rst_i = 1'b0;
    repeat (4) @(negedge clk_i);
    // pulses below threshold, back to back, never sleep
    lpmc_host_i.pulse($urandom_range(1, ENTRY_CYCLES - 2));
    lpmc_host_i.pulse(ENTRY_CYCLES - 1);
    repeat (10) @(negedge clk_i);
    exp_q.push_back({LPMC_SLEEP, 4'h1});
    exp_q.push_back({LPMC_INIT, 4'hE});
    exp_q.push_back({LPMC_RUN, 4'hE});
    lpmc_host_i.pulse(ENTRY_CYCLES);
    n = 0;
    while (state_o !== LPMC_INIT && n < EXIT_CYCLES + 8)
    begin
      @(negedge clk_i);
      n++;
    end
    check(n >= EXIT_CYCLES && n < EXIT_CYCLES + 8, 32'h1);
    n = 0;
    while (state_o !== LPMC_RUN && n < 40)
    begin
      @(negedge clk_i);
      n++;
    end
    // controller returns to run after a single full init phase
    check(state_o, LPMC_RUN);
    check(starts, 32'h1);
    check(busy_cyc, INIT_CYCLES);
    check(exp_q.size(), 32'h0);
    tally_and_finish();
  end
endmodule : tb_top
